// file: hw/aab_pkg.sv
// Constants and types of the logic-mode AND array of one block.
// Assumes nothing beyond a SystemVerilog elaborator.
package aab_pkg;

	// ----------------------------------------
	// Array dimensions
	// ----------------------------------------
	localparam int NUM_IN       = 68;
	localparam int NUM_LINES    = 2 * NUM_IN;
	localparam int NUM_PT       = 164;
	localparam int NUM_LOGIC_PT = 160;
	localparam int NUM_MC       = 32;
	localparam int CLUSTER      = 5;
	localparam int NUM_GCLK     = 4;
	localparam int CFG_BITS     = NUM_PT * NUM_LINES;

	// ----------------------------------------
	// Term positions
	// ----------------------------------------
	localparam int CL_OE_POS  = 0;
	localparam int CL_PROP_POS = 0;
	localparam int CL_GEN_POS  = 1;
	localparam int CL_CLK_POS = 2;
	localparam int CL_PRE_POS = 3;
	localparam int CL_RST_POS = 4;
	localparam int SH_CLK_PT  = 160;
	localparam int SH_CE_PT   = 161;
	localparam int SH_RST_PT  = 162;
	localparam int SH_OE_PT   = 163;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic RST_BIT = 1'b0;

	// ----------------------------------------
	// Block modes and carry-in sources
	// ----------------------------------------
	typedef enum logic [2:0] {
		AAB_MODE_LOGIC,
		AAB_MODE_DPRAM,
		AAB_MODE_PDPRAM,
		AAB_MODE_SPRAM,
		AAB_MODE_FIFO,
		AAB_MODE_CAM
	} aab_mode_t;

	typedef enum logic [1:0] {
		AAB_CIN_CHAIN,
		AAB_CIN_ZERO,
		AAB_CIN_ONE
	} aab_cin_t;

endpackage : aab_pkg

// file: hw/aab_and_array.sv
// Logic-mode AND array, control terms, bypass OR and carry chain of one block.
// Assumes configuration inputs are held static while running and all inputs
// are synchronous to clk_sys.
module aab_and_array (
	// Clock and reset
	input  wire logic                             clk_sys,
	input  wire logic                             rst_n,
	// Routing inputs and device-wide nets
	input  wire logic [aab_pkg::NUM_IN-1:0]       route_in,
	input  wire logic [aab_pkg::NUM_GCLK-1:0]     glb_clk,
	input  wire logic                             glb_rst,
	// Static configuration
	input  wire logic [2:0]                       cfg_mode,
	input  wire logic [aab_pkg::CFG_BITS-1:0]     cfg_conn,
	input  wire logic                             cfg_casc_en,
	input  wire logic [1:0]                       cfg_cin_sel,
	input  wire logic [aab_pkg::NUM_MC-1:0]       cfg_carry_byp,
	input  wire logic [aab_pkg::NUM_MC-1:0]       cfg_pt_clk_sel,
	input  wire logic [2*aab_pkg::NUM_MC-1:0]     cfg_gclk_sel,
	// Cascade from the previous block in the chain
	input  wire logic [aab_pkg::NUM_PT-1:0]       casc_pt_in,
	input  wire logic                             carry_in,
	// Cascade to the next block in the chain
	output logic      [aab_pkg::NUM_PT-1:0]       casc_pt_out,
	output logic                                  carry_out,
	// Toward the OR stage and macrocells
	output logic      [aab_pkg::NUM_LOGIC_PT-1:0] pt_or,
	output logic      [aab_pkg::NUM_MC-1:0]       mc_bypass,
	output logic      [aab_pkg::NUM_MC-1:0]       mc_oe,
	output logic      [aab_pkg::NUM_MC-1:0]       mc_clk,
	output logic      [aab_pkg::NUM_MC-1:0]       mc_pre,
	output logic      [aab_pkg::NUM_MC-1:0]       mc_rst,
	output logic                                  sh_clk,
	output logic                                  sh_ce,
	output logic                                  sh_rst,
	output logic                                  sh_oe,
	output logic      [aab_pkg::NUM_GCLK-1:0]     glb_clk_net
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [aab_pkg::NUM_PT-1:0]       casc_pt;
		logic                             carry;
		logic [aab_pkg::NUM_LOGIC_PT-1:0] pt_or;
		logic [aab_pkg::NUM_MC-1:0]       bypass;
		logic [aab_pkg::NUM_MC-1:0]       oe;
		logic [aab_pkg::NUM_MC-1:0]       clk;
		logic [aab_pkg::NUM_MC-1:0]       pre;
		logic [aab_pkg::NUM_MC-1:0]       rst;
		logic [3:0]                       shared;
		logic [aab_pkg::NUM_GCLK-1:0]     gnet;
	} aab_state_t;

	aab_state_t                       st_r;
	aab_state_t                       st_nxt;
	logic [aab_pkg::NUM_LINES-1:0]    lines;
	logic [aab_pkg::NUM_PT-1:0]       pt_local;
	logic [aab_pkg::NUM_PT-1:0]       pt;
	logic                             logic_mode;
	logic                             carry_seed;
	logic [aab_pkg::NUM_MC:0]         chain;

	// ----------------------------------------
	// Array lines and product terms
	// ----------------------------------------
	assign lines      = {~route_in, route_in};
	assign logic_mode = (cfg_mode == 3'(aab_pkg::AAB_MODE_LOGIC));

	// Each term is one wired-AND cell over all array lines
	genvar t;
	generate
		for (t = 0; t < aab_pkg::NUM_PT; t++) begin : g_pt
			aab_pterm #(
				.WIDTH (aab_pkg::NUM_LINES)
			) u_pterm (
				.lines (lines),
				.conn  (cfg_conn[t*aab_pkg::NUM_LINES +: aab_pkg::NUM_LINES]),
				.term  (pt_local[t])
			);
		end
	endgenerate

	// ----------------------------------------
	// Cascade
	// ----------------------------------------
	// Neighbour's partial terms widen each term to the other block's inputs
	assign pt = pt_local & (cfg_casc_en ? casc_pt_in : {aab_pkg::NUM_PT{1'b1}});

	// ----------------------------------------
	// Carry seed
	// ----------------------------------------
	// Code three is undefined and is treated as the chain input
	always_comb begin
		unique case (cfg_cin_sel)
			2'(aab_pkg::AAB_CIN_ZERO): carry_seed = 1'b0;
			2'(aab_pkg::AAB_CIN_ONE):  carry_seed = 1'b1;
			default:                   carry_seed = carry_in;
		endcase
	end

	// ----------------------------------------
	// Carry chain
	// ----------------------------------------
	assign chain[0] = carry_seed;

	// Generate is cluster term one, propagate is cluster term zero
	genvar m;
	generate
		for (m = 0; m < aab_pkg::NUM_MC; m++) begin : g_carry
			aab_carry_cell u_carry (
				.gen    (pt[m*aab_pkg::CLUSTER+aab_pkg::CL_GEN_POS]),
				.prop   (pt[m*aab_pkg::CLUSTER+aab_pkg::CL_PROP_POS]),
				.bypass (cfg_carry_byp[m]),
				.cin    (chain[m]),
				.cout   (chain[m+1])
			);
		end
	endgenerate

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		int b;
		b = 0;
		st_nxt         = '0;
		// Global clocks are sampled here as data, not used as clocks
		st_nxt.gnet    = glb_clk;
		// Local terms only, so a chain of blocks never feeds back on itself
		st_nxt.casc_pt = pt_local;
		// Memory modes leave every output low but the cascade terms and the global clock nets
		if (logic_mode) begin
			st_nxt.pt_or     = pt[aab_pkg::NUM_LOGIC_PT-1:0];
			st_nxt.shared[0] = pt[aab_pkg::SH_CLK_PT];
			st_nxt.shared[1] = pt[aab_pkg::SH_CE_PT];
			st_nxt.shared[2] = pt[aab_pkg::SH_RST_PT];
			st_nxt.shared[3] = pt[aab_pkg::SH_OE_PT];
			st_nxt.carry  = chain[aab_pkg::NUM_MC];
			for (int i = 0; i < aab_pkg::NUM_MC; i++) begin
				b = i * aab_pkg::CLUSTER;
				st_nxt.bypass[i] = |pt[b +: aab_pkg::CLUSTER];
				st_nxt.oe[i]     = pt[b + aab_pkg::CL_OE_POS];
				st_nxt.pre[i]    = pt[b + aab_pkg::CL_PRE_POS];
				st_nxt.rst[i]    = pt[b + aab_pkg::CL_RST_POS] | glb_rst;
				st_nxt.clk[i]    = cfg_pt_clk_sel[i] ? pt[b + aab_pkg::CL_CLK_POS]
					: glb_clk[cfg_gclk_sel[2*i +: 2]];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= {$bits(aab_state_t){aab_pkg::RST_BIT}};
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------
	// Outputs, all from the state register
	// ----------------------------------------
	// One cycle of latency buys a flip-flop behind every pin
	assign casc_pt_out = st_r.casc_pt;
	assign carry_out   = st_r.carry;
	assign pt_or       = st_r.pt_or;
	assign mc_bypass   = st_r.bypass;
	assign mc_oe       = st_r.oe;
	assign mc_clk      = st_r.clk;
	assign mc_pre      = st_r.pre;
	assign mc_rst      = st_r.rst;
	assign sh_clk      = st_r.shared[0];
	assign sh_ce       = st_r.shared[1];
	assign sh_rst      = st_r.shared[2];
	assign sh_oe       = st_r.shared[3];
	assign glb_clk_net = st_r.gnet;

endmodule // aab_and_array

// ----------------------------------------
// One product term: wired AND of its connected lines
// ----------------------------------------
module aab_pterm #(
	parameter int WIDTH = aab_pkg::NUM_LINES
) (
	// Array lines and this term's connection bits
	input  wire logic [WIDTH-1:0] lines,
	input  wire logic [WIDTH-1:0] conn,
	// Term value
	output logic                  term
);

	// Unconnected lines are forced high so they do not pull the AND low
	assign term = &(lines | ~conn);

endmodule // aab_pterm

// ----------------------------------------
// One carry stage, one per macrocell
// ----------------------------------------
module aab_carry_cell (
	// Cluster terms, bypass choice and incoming carry
	input  wire logic gen,
	input  wire logic prop,
	input  wire logic bypass,
	input  wire logic cin,
	// Carry toward the next macrocell
	output logic      cout
);

	// A bypassed macrocell hands the chain on untouched
	assign cout = bypass ? cin : (gen | (prop & cin));

endmodule // aab_carry_cell

// file: bench/aab_grp_model.sv
// Routing-pool and previous-block stand-in for the AND array.
// Assumes the bench updates its next values off the rising clock edge.
module aab_grp_model (
	// From the bench
	input  wire logic [67:0]  nxt_route,
	input  wire logic [163:0] nxt_casc,
	input  wire logic         nxt_carry,
	// Toward the block
	output logic      [67:0]  route_in,
	output logic      [163:0] casc_pt_in,
	output logic              carry_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// Pool is pure wiring, so no added delay
	assign route_in = nxt_route;
	assign casc_pt_in = nxt_casc;
	assign carry_in = nxt_carry;
endmodule // aab_grp_model

// file: bench/aab_and_array_monitor.sv
// Output relations of the AND array, one cycle behind the inputs.
// Assumes it is bound onto aab_and_array.
module aab_and_array_monitor (
	// Clock, reset and global nets
	input wire logic         clk_sys,
	input wire logic         rst_n,
	input wire logic         glb_rst,
	input wire logic [3:0]   glb_clk,
	// Configuration
	input wire logic [2:0]   cfg_mode,
	input wire logic         cfg_casc_en,
	input wire logic [31:0]  cfg_pt_clk_sel,
	// Cascade
	input wire logic [163:0] casc_pt_in,
	input wire logic [163:0] casc_pt_out,
	// Terms and macrocell controls
	input wire logic [159:0] pt_or,
	input wire logic [31:0]  mc_bypass,
	input wire logic [31:0]  mc_oe,
	input wire logic [31:0]  mc_clk,
	input wire logic [31:0]  mc_pre,
	input wire logic [31:0]  mc_rst,
	input wire logic         carry_out,
	input wire logic         sh_clk,
	input wire logic         sh_ce,
	input wire logic         sh_rst,
	input wire logic         sh_oe,
	input wire logic [3:0]   glb_clk_net
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	function automatic logic [31:0] pk(logic [159:0] v, int j, bit any);
		for (int i = 0; i < 32; i++)
			pk[i] = any ? |v[5*i+:5] : v[5*i+j];
	endfunction
	sequence s_live;
		$past(rst_n) && $past(cfg_mode) == 3'h0;
	endsequence
	property p_mode; cfg_mode != 3'h0 |=> pt_or == '0 && mc_rst == '0 && carry_out == 1'b0; endproperty
	property p_oe; s_live |-> mc_oe == pk(pt_or, 0, 0) && mc_pre == pk(pt_or, 3, 0); endproperty
	property p_rst; s_live |-> mc_rst == (pk(pt_or, 4, 0) | {32{$past(glb_rst)}}); endproperty
	property p_clk; s_live |-> ((mc_clk ^ pk(pt_or, 2, 0)) & $past(cfg_pt_clk_sel)) == 0; endproperty
	property p_byp; s_live |-> mc_bypass == pk(pt_or, 0, 1); endproperty
	property p_gclk; $past(rst_n) |-> glb_clk_net == $past(glb_clk); endproperty
	property p_sh; s_live ##0 !$past(cfg_casc_en) |-> casc_pt_out == {sh_oe, sh_rst, sh_ce, sh_clk, pt_or}; endproperty
	property p_casc;
		s_live ##0 $past(cfg_casc_en) |-> {sh_oe, sh_rst, sh_ce, sh_clk, pt_or} == (casc_pt_out & $past(casc_pt_in));
	endproperty
	a_mode: assert property (p_mode) else $error("outputs live outside logic mode");
	a_oe: assert property (p_oe) else $error("cluster enable or preset term wrong");
	a_rst: assert property (p_rst) else $error("cluster reset term wrong");
	a_clk: assert property (p_clk) else $error("cluster clock term wrong");
	a_byp: assert property (p_byp) else $error("bypass OR wrong");
	a_gclk: assert property (p_gclk) else $error("global clock net wrong");
	a_sh: assert property (p_sh) else $error("shared terms wrong");
	a_casc: assert property (p_casc) else $error("cascade term not ANDed");
endmodule // aab_and_array_monitor

// file: bench/tb_aab_and_array.sv
// Self-checking bench of the AND array: random routing over many configurations.
// Assumes the routing stand-in passes its values straight through.
module tb_aab_and_array;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 0, rst_n = 0, glb_rst = 0, nxt_carry = 0, cfg_casc_en = 0, carry_in, carry_out;
	logic sh_clk, sh_ce, sh_rst, sh_oe;
	logic [1:0] cfg_cin_sel = 0;
	logic [2:0] cfg_mode = 0;
	logic [3:0] glb_clk = 0, glb_clk_net;
	logic [31:0] cfg_carry_byp = 0, cfg_pt_clk_sel = 0, mc_bypass, mc_oe, mc_clk, mc_pre, mc_rst;
	logic [63:0] cfg_gclk_sel = 0;
	logic [67:0] nxt_route = 0, route_in;
	logic [159:0] pt_or;
	logic [163:0] nxt_casc = 0, casc_pt_in, casc_pt_out;
	logic [22303:0] cfg_conn = 0;
	int err_count = 0, n_checks = 0;
	aab_grp_model grp (
		.nxt_route  (nxt_route),
		.nxt_casc   (nxt_casc),
		.nxt_carry  (nxt_carry),
		.route_in   (route_in),
		.casc_pt_in (casc_pt_in),
		.carry_in   (carry_in)
	);
	aab_and_array dut (
		.clk_sys        (clk_sys),
		.rst_n          (rst_n),
		.route_in       (route_in),
		.glb_clk        (glb_clk),
		.glb_rst        (glb_rst),
		.cfg_mode       (cfg_mode),
		.cfg_conn       (cfg_conn),
		.cfg_casc_en    (cfg_casc_en),
		.cfg_cin_sel    (cfg_cin_sel),
		.cfg_carry_byp  (cfg_carry_byp),
		.cfg_pt_clk_sel (cfg_pt_clk_sel),
		.cfg_gclk_sel   (cfg_gclk_sel),
		.casc_pt_in     (casc_pt_in),
		.carry_in       (carry_in),
		.casc_pt_out    (casc_pt_out),
		.carry_out      (carry_out),
		.pt_or          (pt_or),
		.mc_bypass      (mc_bypass),
		.mc_oe          (mc_oe),
		.mc_clk         (mc_clk),
		.mc_pre         (mc_pre),
		.mc_rst         (mc_rst),
		.sh_clk         (sh_clk),
		.sh_ce          (sh_ce),
		.sh_rst         (sh_rst),
		.sh_oe          (sh_oe),
		.glb_clk_net    (glb_clk_net)
	);
	always #2 clk_sys = ~clk_sys;
	task automatic wrap_up();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic cmp(logic [163:0] got, logic [163:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk();
		logic [163:0] l, e;
		logic [31:0] k, b, o, p, r;
		logic lg, c;
		lg = cfg_mode == 3'h0;
		for (int t = 0; t < 164; t++)
			l[t] = &(~cfg_conn[t*136+:136] | {~nxt_route, nxt_route});
		e = l & (cfg_casc_en ? nxt_casc : '1);
		c = cfg_cin_sel == 2'h1 ? 1'b0 : cfg_cin_sel == 2'h2 ? 1'b1 : nxt_carry;
		for (int i = 0; i < 32; i++) begin
			b[i] = |e[5*i+:5];
			k[i] = cfg_pt_clk_sel[i] ? e[5*i+2] : glb_clk[cfg_gclk_sel[2*i+:2]];
			o[i] = e[5*i];
			p[i] = e[5*i+3];
			r[i] = e[5*i+4] | glb_rst;
			if (!cfg_carry_byp[i])
				c = e[5*i+1] | (e[5*i] & c);
		end
		cmp(casc_pt_out, l);
		cmp(pt_or, lg ? e[159:0] : 160'h0);
		cmp({sh_oe, sh_rst, sh_ce, sh_clk}, lg ? e[163:160] : 4'h0);
		cmp(mc_bypass, lg ? b : 32'h0);
		cmp(mc_clk, lg ? k : 32'h0);
		cmp(mc_oe, lg ? o : 32'h0);
		cmp(mc_pre, lg ? p : 32'h0);
		cmp(mc_rst, lg ? r : 32'h0);
		cmp(carry_out, lg & c);
		cmp(glb_clk_net, glb_clk);
	endtask
	initial begin
		// Twice the planned run, reset included
		#(2 * 4 * (10 + 24 * 12 + 8));
		err_count++;
		wrap_up();
	end
	initial begin
		void'($urandom(47));
		repeat (10) @(negedge clk_sys);
		rst_n = 1;
		for (int n = 0; n < 24; n++) begin
			for (int m = 0; m < 12; m++) begin
				@(negedge clk_sys);
				chk();
				if (n == 13 && m == 6) begin
					// Mid-run reset: every output must have dropped by the next falling edge, one cycle later
					rst_n = 1'b0;
					@(negedge clk_sys);
					cmp(casc_pt_out, 164'h0);
					cmp(pt_or, 160'h0);
					cmp({mc_bypass, mc_oe, mc_clk, mc_pre, mc_rst}, 160'h0);
					cmp({carry_out, sh_oe, sh_rst, sh_ce, sh_clk, glb_clk_net}, 9'h0);
					rst_n = 1'b1;
				end
				if (m == 0) begin
					// Config changes only between bursts, held while routing toggles
					cfg_mode = n < 6 ? 3'(n) : 3'h0;
					cfg_casc_en = n[0];
					cfg_cin_sel = n[2:1];
					cfg_carry_byp = n == 8 ? '1 : $urandom;
					cfg_pt_clk_sel = $urandom;
					cfg_gclk_sel = {$urandom, $urandom};
					cfg_conn = 0;
					for (int t = 0; t < 164; t++)
						for (int q = 0; q < (t + n) % 4; q++)
							cfg_conn[t*136+$urandom_range(135)] = 1'b1;
				end
				nxt_route = m < 2 ? {68{m[0]}} : 68'({$urandom, $urandom, $urandom});
				nxt_casc = m == 2 ? '1 : 164'({$urandom, $urandom, $urandom, $urandom, $urandom, $urandom});
				{nxt_carry, glb_rst, glb_clk} = 6'($urandom);
			end
			$display("config %0d done", n);
		end
		@(negedge clk_sys);
		chk();
		wrap_up();
	end
endmodule // tb_aab_and_array
bind aab_and_array aab_and_array_monitor u_mon (
	.clk_sys        (clk_sys),
	.rst_n          (rst_n),
	.glb_rst        (glb_rst),
	.glb_clk        (glb_clk),
	.cfg_mode       (cfg_mode),
	.cfg_casc_en    (cfg_casc_en),
	.cfg_pt_clk_sel (cfg_pt_clk_sel),
	.casc_pt_in     (casc_pt_in),
	.casc_pt_out    (casc_pt_out),
	.pt_or          (pt_or),
	.mc_bypass      (mc_bypass),
	.mc_oe          (mc_oe),
	.mc_clk         (mc_clk),
	.mc_pre         (mc_pre),
	.mc_rst         (mc_rst),
	.carry_out      (carry_out),
	.sh_clk         (sh_clk),
	.sh_ce          (sh_ce),
	.sh_rst         (sh_rst),
	.sh_oe          (sh_oe),
	.glb_clk_net    (glb_clk_net)
);
